// file: common/tte_cfg.svh
/*
 Offsets, field positions, reset values and timing counts for the triggered
 timer and event counter. Assumes a 100 MHz core clock and a 32-bit bus.
*/
`ifndef TTE_CFG_SVH
`define TTE_CFG_SVH

// Register byte offsets
`define TTE_REG_CTRL 5'h00
`define TTE_REG_PERIOD 5'h04
`define TTE_REG_CAPTURE 5'h08
`define TTE_REG_STATUS 5'h0c
`define TTE_REG_COUNT 5'h10

// Control register field positions
`define TTE_CTRL_CLK_LSB 0
`define TTE_CTRL_MODE_LSB 2
`define TTE_CTRL_CAPEDGE_BIT 4
`define TTE_CTRL_START_LSB 5
`define TTE_CTRL_TSTOP_BIT 7
`define TTE_CTRL_ACAP_BIT 8
`define TTE_CTRL_USED_BITS 9

// Reset values
`define TTE_CTRL_RESET 9'h000
`define TTE_PERIOD_RESET 16'hffff
`define TTE_CAPTURE_RESET 16'h0000

// Operating mode field codes
`define TTE_MODE_TIMER 2'b00
`define TTE_MODE_WINDOW 2'b01
`define TTE_MODE_PULSE 2'b10
`define TTE_MODE_PPG 2'b11

// Start control codes
`define TTE_START_STOP 2'b00
`define TTE_START_CMD 2'b01
`define TTE_START_RISE 2'b10
`define TTE_START_FALL 2'b11

// Source clock select: prescaler taps, external pin clock
`define TTE_SRC_EXT 2'b11
`define TTE_DIV0_BITS 11
`define TTE_DIV1_BITS 7
`define TTE_DIV2_BITS 3

// Pin noise filter timing
`define TTE_CLK_PERIOD_NS 10
`define TTE_FILT_REJECT_NS 40
`define TTE_FILT_ACCEPT_NS 120
`define TTE_FILT_REJECT_CYC (`TTE_FILT_REJECT_NS / `TTE_CLK_PERIOD_NS)
`define TTE_FILT_ACCEPT_CYC \
   ((`TTE_FILT_ACCEPT_NS + `TTE_CLK_PERIOD_NS - 1) / `TTE_CLK_PERIOD_NS)
`define TTE_FILT_CYC ((`TTE_FILT_REJECT_CYC + `TTE_FILT_ACCEPT_CYC) / 2)

`endif

// file: common/tte_pkg.sv
/*
 Types shared by the triggered timer and event counter.
 Assumes the constants come from tte_cfg.svh.
*/
`default_nettype none
package tte_pkg;
   // Counter sequencing: waiting for trigger, counting, parked at one
   typedef enum logic [1:0] {
      TTE_IDLE,
      TTE_RUN,
      TTE_PARKED
   } tte_state_type;
endpackage
`default_nettype wire

// file: rtl/tte_input_filter.sv
/*
 Synchroniser and noise filter for the timer input pin.
 Assumes the pin is asynchronous to core_clk_i and bypass_i is core-clock logic.
*/
`timescale 1ns/100ps
`default_nettype none
`include "tte_cfg.svh"

module tte_input_filter
   import tte_pkg::*;
#(
   parameter int unsigned FILT_CYC = `TTE_FILT_CYC
) (
   input wire logic core_clk_i,
   input wire logic resetn_i,
   input wire logic pin_i,
   input wire logic bypass_i,
   output logic level_o
);
   localparam int unsigned CW = $clog2(FILT_CYC + 1);

   logic sync1_reg;
   logic sync2_reg;
   logic level_reg;
   logic [CW-1:0] stable_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Two-stage synchroniser, first stage read only by the second
   always_ff @(posedge core_clk_i) begin
      if (!resetn_i) begin
         sync1_reg <= 1'b0;
         sync2_reg <= 1'b0;
      end else begin
         sync1_reg <= pin_i;
         sync2_reg <= sync1_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // New level must persist FILT_CYC cycles; short glitches reach it only while bypass_i is set
   always_ff @(posedge core_clk_i) begin
      if (!resetn_i) begin
         level_reg <= 1'b0;
         stable_reg <= '0;
      end else if (bypass_i) begin
         level_reg <= sync2_reg;
         stable_reg <= '0;
      end else if (sync2_reg == level_reg) begin
         stable_reg <= '0;
      end else if (stable_reg == CW'(FILT_CYC - 1)) begin
         level_reg <= sync2_reg;
         stable_reg <= '0;
      end else begin
         stable_reg <= stable_reg + CW'(1);
      end
   end

   assign level_o = level_reg;

endmodule
`default_nettype wire

// file: rtl/tte_timer.sv
/*
 Triggered timer and event counter with Avalon-MM register slave.
 Holds the 16-bit up-counter, period compare, capture register and modes.
 Assumes one 100 MHz core clock, synchronous active-low reset, and an
 asynchronous timer input pin filtered inside.
*/
// Register access over Avalon-MM and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
`include "tte_cfg.svh"

// Operation
// - External trigger mode waits, then counts ticks
// - Start field picks rising or falling trigger
// - Period match clears, halts, raises interrupt
// - Stop-select: opposite edge clears, halts, silent
// - Halted counter restarts on next trigger
// - Stop-select off: ignore opposite, repeat triggers
// - Filter drops short pulses, keeps long ones
// - Event mode counts selected pin edges
// - Event match seen at opposite edge
// - Auto-capture copies count every source clock in timer and window modes
// - Window mode counts ticks while gate active
// - Window match raises interrupt, clears counter
// - Pulse mode starts on trigger, edge-mode select
// - Single capture: store, interrupt, set to one, wait
// - Double capture on both edges, clear second
// - Single capture parks counter at one
// - Mode field encodes the four modes
module tte_timer
   import tte_pkg::*;
#(
   parameter int unsigned CNT_W = 16,
   parameter int unsigned FILT_CYC = `TTE_FILT_CYC
) (
   input wire logic core_clk_i,
   input wire logic resetn_i,
   input wire logic [4:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   input wire logic timer_input_pin_i,
   input wire logic low_speed_i,
   output logic timer_irq_o
);

   ////////////////////////////////////////////////////////////////////////////
   // Declarations
   logic [`TTE_CTRL_USED_BITS-1:0] timer_control_reg;
   logic [CNT_W-1:0] period_reg;
   logic [CNT_W-1:0] capture_reg;
   logic [CNT_W-1:0] cnt_reg;
   logic [CNT_W-1:0] cnt_next;
   tte_state_type state_reg;
   tte_state_type state_next;
   logic irq_reg;
   logic irq_next;
   logic cap_load;
   logic [`TTE_DIV0_BITS-1:0] presc_reg;
   logic done_reg;
   logic [31:0] rdata_reg;
   logic pin_level;
   logic level_prev_reg;
   logic rise;
   logic fall;
   logic trig;
   logic opp;
   logic tick;
   logic match;
   logic gate_on;
   logic stopped;
   logic ext_src;
   logic [1:0] source_clock_select;
   logic [1:0] operating_mode_field;
   logic capture_edge_mode;
   logic [1:0] start_control;
   logic trigger_stop_select;
   logic auto_capture_enable;
   logic wr_ok;
   logic [31:0] ctrl_merged;
   logic [31:0] period_merged;

   ////////////////////////////////////////////////////////////////////////////
   // Functions
   // Byte-lane merge for partial writes
   function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0] be);
      logic [31:0] res;
      res = old_v;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            res[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return res;
   endfunction

   // Source clock tick from prescaler taps
   function automatic logic src_tick(input logic [1:0] sel,
                                     input logic [`TTE_DIV0_BITS-1:0] p);
      logic t;
      t = 1'b0;
      case (sel)
         2'b00: t = &p[`TTE_DIV0_BITS-1:0];
         2'b01: t = &p[`TTE_DIV1_BITS-1:0];
         2'b10: t = &p[`TTE_DIV2_BITS-1:0];
         default: t = 1'b0;
      endcase
      return t;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Control fields
   assign source_clock_select = timer_control_reg[`TTE_CTRL_CLK_LSB +: 2];
   assign operating_mode_field = timer_control_reg[`TTE_CTRL_MODE_LSB +: 2];
   assign capture_edge_mode = timer_control_reg[`TTE_CTRL_CAPEDGE_BIT];
   assign start_control = timer_control_reg[`TTE_CTRL_START_LSB +: 2];
   assign trigger_stop_select = timer_control_reg[`TTE_CTRL_TSTOP_BIT];
   assign auto_capture_enable = timer_control_reg[`TTE_CTRL_ACAP_BIT];

   ////////////////////////////////////////////////////////////////////////////
   // Pin filter, edge detection, trigger polarity
   tte_input_filter #(
      .FILT_CYC(FILT_CYC)
   ) i_tte_input_filter (
      .core_clk_i(core_clk_i),
      .resetn_i(resetn_i),
      .pin_i(timer_input_pin_i),
      .bypass_i(low_speed_i),
      .level_o(pin_level)
   );

   always_ff @(posedge core_clk_i) begin
      if (!resetn_i) begin
         level_prev_reg <= 1'b0;
      end else begin
         level_prev_reg <= pin_level;
      end
   end

   // Low bit of the start field picks falling as the trigger
   assign rise = pin_level & ~level_prev_reg;
   assign fall = ~pin_level & level_prev_reg;
   assign trig = start_control[0] ? fall : rise;
   assign opp = start_control[0] ? rise : fall;
   assign gate_on = start_control[0] ? ~pin_level : pin_level;

   ////////////////////////////////////////////////////////////////////////////
   // Prescaler; runs free so a mode change never stretches the first tick
   always_ff @(posedge core_clk_i) begin
      if (!resetn_i) begin
         presc_reg <= '0;
      end else begin
         presc_reg <= presc_reg + `TTE_DIV0_BITS'(1);
      end
   end

   assign tick = src_tick(source_clock_select, presc_reg);
   assign ext_src = (source_clock_select == `TTE_SRC_EXT);
   assign match = (cnt_reg == period_reg);
   assign stopped = (start_control == `TTE_START_STOP);

   ////////////////////////////////////////////////////////////////////////////
   // Counter sequencing per mode
   always_comb begin
      cnt_next = cnt_reg;
      state_next = state_reg;
      irq_next = 1'b0;
      cap_load = 1'b0;
      if (stopped) begin
         cnt_next = '0;
         state_next = TTE_IDLE;
      end else begin
         case (operating_mode_field)
            `TTE_MODE_TIMER: begin
               if (start_control == `TTE_START_CMD) begin
                  // Command-started plain timer
                  if (tick) begin
                     cnt_next = match ? '0 : cnt_reg + CNT_W'(1);
                     irq_next = match;
                  end
                  cap_load = auto_capture_enable && tick;
               end else if (ext_src) begin
                  if (trig) begin
                     cnt_next = cnt_reg + CNT_W'(1);
                  end else if (opp && match) begin
                     cnt_next = '0;
                     irq_next = 1'b1;
                  end
                  cap_load = auto_capture_enable && trig;
               end else begin
                  cap_load = auto_capture_enable && tick;
                  case (state_reg)
                     TTE_RUN: begin
                        // Further triggers are ignored while running
                        if (trigger_stop_select && opp) begin
                           cnt_next = '0;
                           state_next = TTE_IDLE;
                        end else if (tick && match) begin
                           cnt_next = '0;
                           state_next = TTE_IDLE;
                           irq_next = 1'b1;
                        end else if (tick) begin
                           cnt_next = cnt_reg + CNT_W'(1);
                        end
                     end
                     default: begin
                        if (trig) begin
                           state_next = TTE_RUN;
                        end
                     end
                  endcase
               end
            end
            `TTE_MODE_WINDOW: begin
               if (tick && gate_on) begin
                  cnt_next = match ? '0 : cnt_reg + CNT_W'(1);
                  irq_next = match;
               end
               cap_load = auto_capture_enable && tick;
            end
            `TTE_MODE_PULSE: begin
               case (state_reg)
                  TTE_RUN: begin
                     if (opp) begin
                        cap_load = 1'b1;
                        irq_next = 1'b1;
                        if (capture_edge_mode) begin
                           cnt_next = CNT_W'(1);
                           state_next = TTE_PARKED;
                        end
                     end else if (trig && !capture_edge_mode) begin
                        cap_load = 1'b1;
                        irq_next = 1'b1;
                        cnt_next = '0;
                     end else if (tick) begin
                        cnt_next = cnt_reg + CNT_W'(1);
                     end
                  end
                  default: begin
                     if (trig) begin
                        state_next = TTE_RUN;
                     end
                  end
               endcase
            end
            default: begin
               // Pulse generator output lives elsewhere; counter held
               cnt_next = '0;
               state_next = TTE_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!resetn_i) begin
         cnt_reg <= '0;
         state_reg <= TTE_IDLE;
         irq_reg <= 1'b0;
      end else begin
         cnt_reg <= cnt_next;
         state_reg <= state_next;
         irq_reg <= irq_next;
      end
   end

   // Capture register, loaded from the count before it moves
   always_ff @(posedge core_clk_i) begin
      if (!resetn_i) begin
         capture_reg <= `TTE_CAPTURE_RESET;
      end else if (cap_load) begin
         capture_reg <= cnt_reg;
      end
   end

   assign timer_irq_o = irq_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Avalon slave: one wait cycle, then the access completes
   assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~done_reg;
   assign wr_ok = avs_write_i & done_reg;
   assign avs_readdata_o = rdata_reg;

   always_ff @(posedge core_clk_i) begin
      if (!resetn_i) begin
         done_reg <= 1'b0;
      end else begin
         done_reg <= (avs_read_i | avs_write_i) & ~done_reg;
      end
   end

   // Read data sampled in the wait cycle; unmapped reads return zero
   always_ff @(posedge core_clk_i) begin
      if (!resetn_i) begin
         rdata_reg <= 32'h0000_0000;
      end else if (avs_read_i && !done_reg) begin
         if (avs_address_i == `TTE_REG_CTRL) begin
            rdata_reg <= 32'(timer_control_reg);
         end else if (avs_address_i == `TTE_REG_PERIOD) begin
            rdata_reg <= 32'(period_reg);
         end else if (avs_address_i == `TTE_REG_CAPTURE) begin
            rdata_reg <= 32'(capture_reg);
         end else if (avs_address_i == `TTE_REG_STATUS) begin
            rdata_reg <= {30'h0, state_reg == TTE_PARKED, state_reg == TTE_RUN};
         end else if (avs_address_i == `TTE_REG_COUNT) begin
            rdata_reg <= 32'(cnt_reg);
         end else begin
            rdata_reg <= 32'h0000_0000;
         end
      end
   end

   // Writable registers; other offsets ignore writes
   assign ctrl_merged = be_merge(32'(timer_control_reg), avs_writedata_i, avs_byteenable_i);
   assign period_merged = be_merge(32'(period_reg), avs_writedata_i, avs_byteenable_i);

   always_ff @(posedge core_clk_i) begin
      if (!resetn_i) begin
         timer_control_reg <= `TTE_CTRL_RESET;
         period_reg <= `TTE_PERIOD_RESET;
      end else if (wr_ok) begin
         if (avs_address_i == `TTE_REG_CTRL) begin
            timer_control_reg <= ctrl_merged[`TTE_CTRL_USED_BITS-1:0];
         end else if (avs_address_i == `TTE_REG_PERIOD) begin
            period_reg <= period_merged[CNT_W-1:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Assertions
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!resetn_i);

   logic ext_trig_mode;
   assign ext_trig_mode = !stopped && !ext_src && start_control != `TTE_START_CMD
                          && operating_mode_field == `TTE_MODE_TIMER;

   property p_ext_idle;
      ext_trig_mode && state_reg == TTE_IDLE && !wr_ok |=> cnt_reg == 0;
   endproperty
   a_ext_idle: assert property (p_ext_idle) else $error("idle count moved");

   property p_ext_match;
      ext_trig_mode && !wr_ok && state_reg == TTE_RUN && tick && match
         && !(trigger_stop_select && opp)
      |=> timer_irq_o && cnt_reg == 0 && state_reg == TTE_IDLE;
   endproperty
   a_ext_match: assert property (p_ext_match) else $error("match not handled");

   property p_ext_stop;
      ext_trig_mode && !wr_ok && state_reg == TTE_RUN && trigger_stop_select && opp
      |=> !timer_irq_o && cnt_reg == 0 && state_reg == TTE_IDLE;
   endproperty
   a_ext_stop: assert property (p_ext_stop) else $error("stop edge wrong");

   property p_ext_ignore;
      ext_trig_mode && !wr_ok && state_reg == TTE_RUN && !trigger_stop_select && !tick
      |=> state_reg == TTE_RUN && $stable(cnt_reg);
   endproperty
   a_ext_ignore: assert property (p_ext_ignore) else $error("edge not ignored");

   property p_event_count;
      !stopped && ext_src && !wr_ok && operating_mode_field == `TTE_MODE_TIMER
         && start_control[1] && trig
      |=> cnt_reg == $past(cnt_reg) + 16'h0001;
   endproperty
   a_event_count: assert property (p_event_count) else $error("event lost");

   property p_window_hold;
      !stopped && !wr_ok && operating_mode_field == `TTE_MODE_WINDOW && !gate_on
      |=> $stable(cnt_reg) && !timer_irq_o;
   endproperty
   a_window_hold: assert property (p_window_hold) else $error("gate leak");

   property p_window_match;
      !stopped && !wr_ok && operating_mode_field == `TTE_MODE_WINDOW && gate_on && tick
         && match
      |=> timer_irq_o && cnt_reg == 0;
   endproperty
   a_window_match: assert property (p_window_match) else $error("window match missed");

   property p_single_cap;
      !stopped && !wr_ok && operating_mode_field == `TTE_MODE_PULSE
         && capture_edge_mode && state_reg == TTE_RUN && opp
      |=> capture_reg == $past(cnt_reg) && cnt_reg == 1 && timer_irq_o
          ##1 !timer_irq_o;
   endproperty
   a_single_cap: assert property (p_single_cap) else $error("single capture bad");

   property p_double_cap;
      !stopped && !wr_ok && operating_mode_field == `TTE_MODE_PULSE
         && !capture_edge_mode && state_reg == TTE_RUN && trig
      |=> capture_reg == $past(cnt_reg) && cnt_reg == 0 && state_reg == TTE_RUN;
   endproperty
   a_double_cap: assert property (p_double_cap) else $error("double capture bad");

   property p_auto_cap;
      !stopped && !wr_ok && auto_capture_enable && tick
         && operating_mode_field == `TTE_MODE_WINDOW
      |=> capture_reg == $past(cnt_reg);
   endproperty
   a_auto_cap: assert property (p_auto_cap) else $error("auto capture missed");

   c_ext_match: cover property (ext_trig_mode && timer_irq_o);
   c_event_irq: cover property (ext_src && timer_irq_o);
   c_single: cover property (state_reg == TTE_PARKED ##[1:1000] state_reg == TTE_RUN);
   c_window: cover property (operating_mode_field == `TTE_MODE_WINDOW && timer_irq_o);

endmodule
`default_nettype wire

// file: tb/tte_pulse_src.sv
/*
 Model of the pulse source that drives the timer input pin.
 Assumes the bench calls drive() right after a rising core clock edge.
*/
`timescale 1ns/100ps
`default_nettype none

module tte_pulse_src (
   input wire logic core_clk_i,
   output logic pin_o
);
   ////////////////////////////////////////////////////////////////////
   // Pin starts low; a real source is never left floating here
   initial begin
      pin_o = 1'b0;
   end

   // Each level is held whole cycles, and never under two of them
   task automatic drive(input logic lvl, input int n);
      @(posedge core_clk_i);
      pin_o <= lvl;
      repeat ((n < 2) ? 1 : n - 1) @(posedge core_clk_i);
   endtask
endmodule
`default_nettype wire

// file: tb/triggered_timer_event_counter_tb.sv
/*
 Self-checking bench for the triggered timer and event counter.
 Assumes tte_cfg.svh on the include path and the pulse source model.
*/
`timescale 1ns/100ps
`default_nettype none
`include "tte_cfg.svh"

module triggered_timer_event_counter_tb;
   logic core_clk_i;
   logic resetn_i;
   logic [4:0] adr;
   logic rd_en;
   logic wr_en;
   logic [31:0] wdat;
   logic [31:0] rdat;
   logic wait_req;
   logic pin;
   logic low_speed;
   logic irq;
   logic [31:0] irq_n = '0;
   logic [31:0] irq_base = '0;
   logic [31:0] q;
   int err_total;
   int n_tests;
   int cyc;

   tte_timer i_tte_timer (
      .core_clk_i(core_clk_i),
      .resetn_i(resetn_i),
      .avs_address_i(adr),
      .avs_read_i(rd_en),
      .avs_write_i(wr_en),
      .avs_writedata_i(wdat),
      .avs_byteenable_i(4'hf),
      .avs_readdata_o(rdat),
      .avs_waitrequest_o(wait_req),
      .timer_input_pin_i(pin),
      .low_speed_i(low_speed),
      .timer_irq_o(irq)
   );

   tte_pulse_src i_tte_pulse_src (
      .core_clk_i(core_clk_i),
      .pin_o(pin)
   );

   ////////////////////////////////////////////////////////////////////
   // 100 MHz clock
   initial begin
      core_clk_i = 1'b0;
      forever #5 core_clk_i = ~core_clk_i;
   end

   // Interrupt tally and hang guard; whole run is near 3250 cycles
   always @(posedge core_clk_i) begin
      irq_n <= irq_n + {31'h0, irq === 1'b1};
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_total++;
         conclude();
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Verdict in one place
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // One Avalon access; held until waitrequest is sampled low
   task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
      @(posedge core_clk_i);
      adr <= a;
      wr_en <= w;
      rd_en <= ~w;
      wdat <= d;
      do @(posedge core_clk_i); while (wait_req !== 1'b0);
      q = rdat;
      rd_en <= 1'b0;
      wr_en <= 1'b0;
   endtask

   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask

   task automatic rdc(input logic [4:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(q, e);
   endtask

   // Range check where prescaler phase blurs the exact figure
   task automatic rng(input logic [4:0] a, input logic [31:0] lo, input logic [31:0] hi);
      bus(1'b0, a, 32'h0);
      chk({31'h0, q >= lo && q <= hi}, 32'h1);
   endtask

   task automatic irqs(input logic [31:0] e);
      chk(irq_n - irq_base, e);
      irq_base = irq_n;
   endtask

   task automatic pulse(input int hi, input int lo);
      i_tte_pulse_src.drive(1'b1, hi);
      i_tte_pulse_src.drive(1'b0, lo);
   endtask

   ////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      resetn_i = 1'b0;
      adr = 5'h00;
      rd_en = 1'b0;
      wr_en = 1'b0;
      wdat = 32'h0;
      low_speed = 1'b0;
      repeat (3) @(posedge core_clk_i);
      resetn_i <= 1'b1;
      // Reset values, period width, read-only and unmapped places
      rdc(`TTE_REG_CTRL, 32'h0);
      rdc(`TTE_REG_PERIOD, 32'hffff);
      wr(`TTE_REG_PERIOD, 32'h1234_5678);
      rdc(`TTE_REG_PERIOD, 32'h5678);
      wr(`TTE_REG_CAPTURE, 32'h55);
      rdc(`TTE_REG_CAPTURE, 32'h0);
      rdc(5'h14, 32'h0);
      // Event counter on rising edges with auto-capture
      wr(`TTE_REG_PERIOD, 32'h3);
      wr(`TTE_REG_CTRL, 32'h143);
      pulse(20, 20);
      pulse(20, 20);
      rdc(`TTE_REG_COUNT, 32'h2);
      rdc(`TTE_REG_CAPTURE, 32'h1);
      pulse(3, 20);
      rdc(`TTE_REG_COUNT, 32'h2);
      pulse(20, 20);
      irqs(32'h1);
      rdc(`TTE_REG_COUNT, 32'h0);
      // Falling edges; short pulse passes once the filter is bypassed
      wr(`TTE_REG_CTRL, 32'h0);
      wr(`TTE_REG_CTRL, 32'h063);
      pulse(20, 20);
      low_speed <= 1'b1;
      pulse(3, 20);
      rdc(`TTE_REG_COUNT, 32'h2);
      low_speed <= 1'b0;
      // External trigger with stop on the opposite edge
      wr(`TTE_REG_CTRL, 32'h0);
      wr(`TTE_REG_PERIOD, 32'h20);
      wr(`TTE_REG_CTRL, 32'h0c2);
      i_tte_pulse_src.drive(1'b0, 100);
      rdc(`TTE_REG_COUNT, 32'h0);
      i_tte_pulse_src.drive(1'b1, 100);
      rng(`TTE_REG_COUNT, 9, 13);
      i_tte_pulse_src.drive(1'b0, 30);
      irqs(32'h0);
      rdc(`TTE_REG_COUNT, 32'h0);
      pulse(400, 20);
      irqs(32'h1);
      rdc(`TTE_REG_COUNT, 32'h0);
      pulse(400, 20);
      irqs(32'h1);
      // Without stop: a restart on the second trigger would miss the window
      wr(`TTE_REG_CTRL, 32'h0);
      wr(`TTE_REG_CTRL, 32'h042);
      pulse(50, 50);
      pulse(50, 220);
      irqs(32'h1);
      // Pulse width, single-edge capture
      wr(`TTE_REG_CTRL, 32'h0);
      wr(`TTE_REG_CTRL, 32'h05a);
      pulse(200, 40);
      irqs(32'h1);
      rng(`TTE_REG_CAPTURE, 23, 27);
      rdc(`TTE_REG_COUNT, 32'h1);
      // Pulse width, double-edge capture
      wr(`TTE_REG_CTRL, 32'h0);
      wr(`TTE_REG_CTRL, 32'h04a);
      pulse(200, 200);
      i_tte_pulse_src.drive(1'b1, 40);
      irqs(32'h2);
      rng(`TTE_REG_CAPTURE, 48, 52);
      rng(`TTE_REG_COUNT, 2, 8);
      // Window mode, both gate polarities
      wr(`TTE_REG_CTRL, 32'h0);
      i_tte_pulse_src.drive(1'b0, 30);
      wr(`TTE_REG_PERIOD, 32'hffff);
      wr(`TTE_REG_CTRL, 32'h146);
      i_tte_pulse_src.drive(1'b0, 200);
      rdc(`TTE_REG_COUNT, 32'h0);
      i_tte_pulse_src.drive(1'b1, 160);
      rng(`TTE_REG_COUNT, 18, 23);
      rng(`TTE_REG_CAPTURE, 17, 23);
      wr(`TTE_REG_CTRL, 32'h0);
      wr(`TTE_REG_CTRL, 32'h066);
      i_tte_pulse_src.drive(1'b1, 160);
      rdc(`TTE_REG_COUNT, 32'h0);
      i_tte_pulse_src.drive(1'b0, 160);
      rng(`TTE_REG_COUNT, 18, 23);
      // Window match: about 50 gated cycles give six or seven ticks
      wr(`TTE_REG_CTRL, 32'h0);
      wr(`TTE_REG_PERIOD, 32'h3);
      wr(`TTE_REG_CTRL, 32'h046);
      pulse(50, 20);
      irqs(32'h1);
      rng(`TTE_REG_COUNT, 1, 3);
      conclude();
   end
endmodule
`default_nettype wire
